// ==== core/swbt_pkg.sv ====
// constants and types shared by the byte transfer engine and its fifo
package swbt_pkg;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_BYTE = 8'ha5;
   localparam logic [7:0] CMD_READ_BYTE = 8'h96;

   // ------------------------------------------------------------
   // clocks and latency budget
   // ------------------------------------------------------------
   localparam int MCLK_NS = 50;
   localparam int LINK_CLK_NS = 80;
   localparam int START_MAX_PS = 262500;

   // ------------------------------------------------------------
   // slot timing in ns, standard and overdrive speed
   // ------------------------------------------------------------
   localparam int SLOT_STD_NS = 70000;
   localparam int SLOT_OD_NS = 10000;
   localparam int W0LOW_STD_NS = 60000;
   localparam int W0LOW_OD_NS = 7500;
   localparam int W1LOW_STD_NS = 8000;
   localparam int W1LOW_OD_NS = 1000;
   localparam int MSR_STD_NS = 14000;
   localparam int MSR_OD_NS = 2000;
   localparam int APU_STD_NS = 2500;
   localparam int APU_OD_NS = 500;

   // ------------------------------------------------------------
   // the same times in link clock cycles, rounded up
   // ------------------------------------------------------------
   localparam logic [9:0] SLOT_STD_CYC =
      10'((SLOT_STD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] SLOT_OD_CYC =
      10'((SLOT_OD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] W0_STD_CYC =
      10'((W0LOW_STD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] W0_OD_CYC =
      10'((W0LOW_OD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] W1_STD_CYC =
      10'((W1LOW_STD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] W1_OD_CYC =
      10'((W1LOW_OD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] MSR_STD_CYC =
      10'((MSR_STD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] MSR_OD_CYC =
      10'((MSR_OD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] APU_STD_CYC =
      10'((APU_STD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
   localparam logic [9:0] APU_OD_CYC =
      10'((APU_OD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);

   // ------------------------------------------------------------
   // data path and reset values
   // ------------------------------------------------------------
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic LINE_IDLE_OE_N = 1'b1;

   typedef enum logic [1:0] {LS_IDLE, LS_LOW, LS_REST} swbt_lstate_t;

endpackage

// ==== core/swbt_fifo_if.sv ====
// handshake signals between the engine and its byte fifo
`timescale 1ns/10ps
interface swbt_fifo_if #(parameter int W = 8);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;
   modport fifo (input wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, rd_ready,
                 input wr_ready, rd_valid, rd_data);
endinterface

// ==== core/swbt_fifo.sv ====
// synchronous byte fifo with valid and ready on both sides
`timescale 1ns/10ps
module swbt_fifo
   import swbt_pkg::*;
#(
   parameter int W = FIFO_WIDTH,
   parameter int D = FIFO_DEPTH
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   swbt_fifo_if.fifo f
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } swbt_fstate_t;

   swbt_fstate_t s;
   swbt_fstate_t next_s;
   logic [W-1:0] mem [D];
   logic full;
   logic empty;

   assign empty = (s.wr_ptr == s.rd_ptr);
   assign full = (s.wr_ptr[AW-1:0] == s.rd_ptr[AW-1:0]) &&
                 (s.wr_ptr[AW] != s.rd_ptr[AW]);
   assign f.wr_ready = !full;
   assign f.rd_valid = !empty;
   assign f.rd_data = mem[s.rd_ptr[AW-1:0]];

   always_comb begin
      next_s = s;
      if (f.wr_valid && !full) begin
         next_s.wr_ptr = s.wr_ptr + 1'b1;
      end
      if (f.rd_ready && !empty) begin
         next_s.rd_ptr = s.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (f.wr_valid && !full) begin
         mem[s.wr_ptr[AW-1:0]] <= f.wr_data;
      end
   end
endmodule

// ==== core/swbt_engine.sv ====
// byte write and byte read engine of the host to single wire bridge
//
// What this block does
// R1: write-byte code plus one data byte sends that byte on the line
// R2: line bits go least significant first; start only after full byte
// R3: write activity starts within 262.5ns of last data bit fall; engine starts up to 290ns after the mclk_in edge taking the byte
// R4: write ends within eight slots plus 262.5ns of last bit fall; engine: up to eight slots plus 290ns after the mclk_in edge taking the byte
// R5: busy at write code: refuse code and data byte, ignore command
// R6: read-byte code makes eight read slots, result to read data
// R7: every read slot is a write-one slot that also samples
// R8: busy at read code: refuse the code, ignore command
// R9: read starts within 262.5ns of code ack fall; ends 8 slots later
// R10: busy flag stays set for the eight slots of either command
// R11: accepted byte command points the read pointer at status
// R12: host sets read pointer to read data, then reads the byte
// R13: byte write honours speed, strong and active pullup settings
// R14: byte read honours speed and active pullup, no strong pullup
// R15: write-one slot samples the line at the master sample time
// R16: read bits assemble least significant first, first slot bit 0
`timescale 1ns/10ps
module swbt_engine
   import swbt_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic link_clk_in,
   input wire logic cmd_strobe_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic code_ack_edge_in,
   input wire logic data_strobe_in,
   input wire logic [7:0] data_byte_in,
   input wire logic line_speed_select_in,
   input wire logic strong_pullup_enable_in,
   input wire logic active_pullup_enable_in,
   output logic code_ack_out,
   output logic data_ack_out,
   output logic ptr_to_status_out,
   output logic line_busy_flag_out,
   output logic [7:0] read_data_out,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_n_out,
   output logic strong_pullup_out,
   output logic active_pullup_out
);

   // ------------------------------------------------------------
   // state of the host side, on mclk_in
   // ------------------------------------------------------------
   typedef struct packed {
      logic busy;
      logic pend_wr;
      logic pend_rd;
      logic req_tgl;
      logic req_busy;
      logic [7:0] pay_byte;
      logic pay_rd;
      logic pay_spd;
      logic pay_spu;
      logic pay_apu;
      logic dn_s1;
      logic dn_s2;
      logic dn_prev;
      logic [7:0] rd_data;
      logic ptr_stat;
   } swbt_hstate_t;

   // ------------------------------------------------------------
   // state of the line side, on link_clk_in
   // ------------------------------------------------------------
   typedef struct packed {
      logic rq_s1;
      logic rq_s2;
      logic rq_prev;
      logic ln_s1;
      logic ln_s2;
      swbt_lstate_t st;
      logic [2:0] idx;
      logic [9:0] cnt;
      logic [7:0] tx;
      logic [7:0] rx;
      logic rd;
      logic spd;
      logic strong_pullup_enable;
      logic active_pullup_enable;
      logic dn_tgl;
      logic oe_n;
      logic spu_on;
      logic apu_on;
   } swbt_lnstate_t;

   swbt_hstate_t s;
   swbt_hstate_t next_s;
   swbt_lnstate_t q;
   swbt_lnstate_t next_q;

   swbt_fifo_if #(.W(FIFO_WIDTH)) fif ();

   swbt_fifo #(
      .W(FIFO_WIDTH),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .f(fif.fifo)
   );

   logic is_byte_cmd;
   logic done_seen;
   logic [9:0] slot_c;
   logic [9:0] low_c;
   logic [9:0] msr_c;
   logic [9:0] apu_c;

   // ------------------------------------------------------------
   // host side handshakes
   // ------------------------------------------------------------
   assign is_byte_cmd = (cmd_code_in == CMD_WRITE_BYTE) ||
                        (cmd_code_in == CMD_READ_BYTE);
   assign code_ack_out = !s.busy; // [R5] [R8]
   assign data_ack_out = s.pend_wr && fif.wr_ready; // [R5]
   assign done_seen = (s.dn_s2 != s.dn_prev);
   assign fif.wr_valid = s.pend_wr && data_strobe_in;
   assign fif.wr_data = data_byte_in;
   // the fifo drains only while no line transfer is outstanding
   assign fif.rd_ready = !s.req_busy && !s.pend_rd;

   assign ptr_to_status_out = s.ptr_stat;
   assign line_busy_flag_out = s.busy;
   assign read_data_out = s.rd_data;

   always_comb begin
      next_s = s;
      next_s.ptr_stat = 1'b0;
      next_s.dn_s1 = q.dn_tgl;
      next_s.dn_s2 = s.dn_s1;
      next_s.dn_prev = s.dn_s2;
      // line side finished; its result register is stable now
      if (done_seen) begin
         next_s.busy = 1'b0; // [R10]
         next_s.req_busy = 1'b0;
         if (s.pay_rd) begin
            next_s.rd_data = q.rx; // [R6]
         end
      end
      // a new code while busy is left alone: [R5] [R8]
      if (cmd_strobe_in && !s.busy && is_byte_cmd) begin
         next_s.busy = 1'b1; // [R10]
         next_s.ptr_stat = 1'b1; // [R11]
         if (cmd_code_in == CMD_WRITE_BYTE) begin
            next_s.pend_wr = 1'b1; // [R1]
         end else begin
            next_s.pend_rd = 1'b1; // [R6]
         end
      end
      if (s.pend_wr && data_strobe_in) begin
         next_s.pend_wr = 1'b0;
         // byte refused by a full fifo: drop the command
         if (!fif.wr_ready) begin
            next_s.busy = 1'b0;
         end
      end
      // read launches at the fall of the code acknowledge bit
      if (s.pend_rd && code_ack_edge_in) begin
         next_s.pend_rd = 1'b0;
         next_s.req_tgl = !s.req_tgl; // [R9]
         next_s.req_busy = 1'b1;
         next_s.pay_rd = 1'b1;
         next_s.pay_byte = 8'hff; // [R7]
         next_s.pay_spd = line_speed_select_in; // [R14]
         next_s.pay_spu = 1'b0; // [R14]
         next_s.pay_apu = active_pullup_enable_in; // [R14]
      end else if (fif.rd_valid && fif.rd_ready) begin
         // write launches as soon as the whole byte is in [R2] [R3]
         next_s.req_tgl = !s.req_tgl;
         next_s.req_busy = 1'b1;
         next_s.pay_rd = 1'b0;
         next_s.pay_byte = fif.rd_data; // [R1]
         next_s.pay_spd = line_speed_select_in; // [R13]
         next_s.pay_spu = strong_pullup_enable_in; // [R13]
         next_s.pay_apu = active_pullup_enable_in; // [R13]
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // line side slot timing
   // ------------------------------------------------------------
   always_comb begin
      slot_c = q.spd ? SLOT_OD_CYC : SLOT_STD_CYC;
      msr_c = q.spd ? MSR_OD_CYC : MSR_STD_CYC; // [R15]
      apu_c = q.spd ? APU_OD_CYC : APU_STD_CYC;
      if (q.tx[q.idx]) begin
         low_c = q.spd ? W1_OD_CYC : W1_STD_CYC;
      end else begin
         low_c = q.spd ? W0_OD_CYC : W0_STD_CYC;
      end
   end

   assign line_out = 1'b0;
   assign line_oe_n_out = q.oe_n;
   assign strong_pullup_out = q.spu_on;
   assign active_pullup_out = q.apu_on;

   always_comb begin
      next_q = q;
      next_q.rq_s1 = s.req_tgl;
      next_q.rq_s2 = q.rq_s1;
      next_q.rq_prev = q.rq_s2;
      next_q.ln_s1 = line_in;
      next_q.ln_s2 = q.ln_s1;
      // sample every slot; only a read hands the byte over
      if (q.st != LS_IDLE && q.cnt == msr_c - 10'h001) begin
         next_q.rx[q.idx] = q.ln_s2; // [R15] [R16]
      end
      case (q.st)
         LS_IDLE: begin
            // payload is held by the host side until done returns
            if (q.rq_s2 != q.rq_prev) begin
               next_q.tx = s.pay_byte;
               next_q.rd = s.pay_rd;
               next_q.spd = s.pay_spd;
               next_q.strong_pullup_enable = s.pay_spu;
               next_q.active_pullup_enable = s.pay_apu;
               next_q.idx = 3'h0; // [R2] [R16]
               next_q.cnt = 10'h000;
               next_q.spu_on = 1'b0;
               next_q.oe_n = 1'b0; // [R3] [R9]
               next_q.st = LS_LOW;
            end
         end
         LS_LOW: begin
            next_q.cnt = q.cnt + 10'h001;
            if (q.cnt == low_c - 10'h001) begin
               next_q.oe_n = 1'b1; // [R7]
               next_q.apu_on = q.active_pullup_enable; // [R13] [R14]
               next_q.st = LS_REST;
            end
         end
         LS_REST: begin
            next_q.cnt = q.cnt + 10'h001;
            if (q.cnt == low_c + apu_c - 10'h001) begin
               next_q.apu_on = 1'b0;
            end
            if (q.cnt == slot_c - 10'h001) begin
               next_q.apu_on = 1'b0;
               next_q.cnt = 10'h000;
               if (q.idx == LAST_BIT) begin
                  next_q.dn_tgl = !q.dn_tgl; // [R4] [R10]
                  next_q.spu_on = q.strong_pullup_enable && !q.rd; // [R13] [R14]
                  next_q.st = LS_IDLE;
               end else begin
                  next_q.idx = q.idx + 3'h1; // [R2]
                  next_q.oe_n = 1'b0;
                  next_q.st = LS_LOW;
               end
            end
         end
         default: begin
            next_q.st = LS_IDLE;
            next_q.oe_n = LINE_IDLE_OE_N;
         end
      endcase
   end

   always_ff @(posedge link_clk_in or posedge reset_in) begin
      if (reset_in) begin
         q <= '0;
         q.oe_n <= LINE_IDLE_OE_N;
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // checks on the host side
   // ------------------------------------------------------------
   busy_refuse_a: assert property ( // [R5] [R8]
      @(posedge mclk_in) disable iff (reset_in)
      cmd_strobe_in && s.busy && !done_seen |->
         !code_ack_out ##1 !ptr_to_status_out)
      else $error("code taken while line busy");

   ptr_status_a: assert property ( // [R11]
      @(posedge mclk_in) disable iff (reset_in)
      cmd_strobe_in && !s.busy && is_byte_cmd |=>
         ptr_to_status_out && line_busy_flag_out)
      else $error("accepted command did not set pointer and busy");

   data_refuse_a: assert property ( // [R5]
      @(posedge mclk_in) disable iff (reset_in)
      data_strobe_in && !s.pend_wr |-> !data_ack_out)
      else $error("data byte acknowledged without write command");

   read_launch_a: assert property ( // [R9]
      @(posedge mclk_in) disable iff (reset_in)
      s.pend_rd && code_ack_edge_in |=>
         s.req_busy && s.pay_rd && (s.req_tgl != $past(s.req_tgl)))
      else $error("read not launched at code acknowledge");

   busy_hold_a: assert property ( // [R10]
      @(posedge mclk_in) disable iff (reset_in)
      s.req_busy |-> line_busy_flag_out)
      else $error("busy flag dropped during transfer");

   // ------------------------------------------------------------
   // checks on the line side
   // ------------------------------------------------------------
   read_one_a: assert property ( // [R7]
      @(posedge link_clk_in) disable iff (reset_in)
      $rose(line_oe_n_out) && q.rd |->
         q.cnt == (q.spd ? W1_OD_CYC : W1_STD_CYC))
      else $error("read slot low time is not a write-one");

   write_bit_a: assert property ( // [R1]
      @(posedge link_clk_in) disable iff (reset_in)
      $rose(line_oe_n_out) && !q.rd && !q.tx[q.idx] |->
         q.cnt == (q.spd ? W0_OD_CYC : W0_STD_CYC))
      else $error("write-zero slot low time wrong");

   lsb_order_a: assert property ( // [R2]
      @(posedge link_clk_in) disable iff (reset_in)
      q.st == LS_REST && q.cnt == slot_c - 10'h001 &&
         q.idx != LAST_BIT |=>
         q.st == LS_LOW && q.idx == 3'($past(q.idx) + 3'h1))
      else $error("bit order broken");

   sample_bit_a: assert property ( // [R15]
      @(posedge link_clk_in) disable iff (reset_in)
      q.st != LS_IDLE && q.cnt == msr_c - 10'h001 |=>
         q.rx[$past(q.idx)] == $past(q.ln_s2))
      else $error("line not sampled at master sample time");

   pullup_a: assert property ( // [R14]
      @(posedge link_clk_in) disable iff (reset_in)
      (strong_pullup_out |-> !q.rd && q.strong_pullup_enable) and
      (active_pullup_out |-> q.active_pullup_enable && line_oe_n_out))
      else $error("pullup driven against its setting");
endmodule

// ==== tb/swbt_line_model.sv ====
// behavioural single-wire slave that answers read slots and records bits
`timescale 1ns/10ps
module swbt_line_model (
   input wire logic line_in,
   input wire logic od_in,
   input wire logic [7:0] tx_in,
   output logic oe_n_out,
   output logic [7:0] rx_out,
   output int slots_out
);
   // ------------------------------------------------------------
   // slot follower
   // ------------------------------------------------------------
   localparam int HOLD_STD_NS = 30000;
   localparam int HOLD_OD_NS = 4000;

   initial begin
      oe_n_out = 1'b1;
      rx_out = 8'h00;
      slots_out = 0;
      forever begin
         @(negedge line_in);
         // a zero is answered by holding the line past the master sample
         if (tx_in[slots_out % 8] == 1'b0) begin
            oe_n_out = 1'b0;
         end
         #(od_in ? HOLD_OD_NS : HOLD_STD_NS);
         rx_out = {line_in, rx_out[7:1]};
         oe_n_out = 1'b1;
         slots_out = slots_out + 1;
      end
   end
endmodule

// ==== tb/swbt_engine_tb_top.sv ====
// self-checking bench of the byte write and byte read engine
`timescale 1ns/10ps
module swbt_engine_tb_top
   import swbt_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int START_SLACK_NS = 400;
   localparam int END_SLACK_NS = 1000;
   localparam int WAIT_LIMIT = 20000;
   logic mclk_in, link_clk_in, reset_in;
   logic cmd_strobe_in, code_ack_edge_in, data_strobe_in;
   logic [7:0] cmd_code_in, data_byte_in, read_data_out, tx_byte, rx_byte;
   logic line_speed_select_in, strong_pullup_enable_in;
   logic active_pullup_enable_in;
   logic code_ack_out, data_ack_out, ptr_to_status_out, line_busy_flag_out;
   logic line_out, line_oe_n_out, strong_pullup_out, active_pullup_out;
   logic slave_oe_n;
   wire line_w;
   int err_total, total_checks, seed, slots, phase;
   logic early, apu_seen;
   realtime first_low;

   // open-drain line with pull-up
   assign line_w = (line_oe_n_out === 1'b0 ? line_out : 1'b1) & slave_oe_n;

   swbt_engine dut_u (.mclk_in(mclk_in), .reset_in(reset_in),
      .link_clk_in(link_clk_in), .cmd_strobe_in(cmd_strobe_in),
      .cmd_code_in(cmd_code_in), .code_ack_edge_in(code_ack_edge_in),
      .data_strobe_in(data_strobe_in), .data_byte_in(data_byte_in),
      .line_speed_select_in(line_speed_select_in),
      .strong_pullup_enable_in(strong_pullup_enable_in),
      .active_pullup_enable_in(active_pullup_enable_in),
      .code_ack_out(code_ack_out), .data_ack_out(data_ack_out),
      .ptr_to_status_out(ptr_to_status_out),
      .line_busy_flag_out(line_busy_flag_out),
      .read_data_out(read_data_out), .line_in(line_w), .line_out(line_out),
      .line_oe_n_out(line_oe_n_out), .strong_pullup_out(strong_pullup_out),
      .active_pullup_out(active_pullup_out));

   swbt_line_model slave_u (.line_in(line_w), .od_in(line_speed_select_in),
      .tx_in(tx_byte), .oe_n_out(slave_oe_n), .rx_out(rx_byte),
      .slots_out(slots));

   // ------------------------------------------------------------
   // clocks and line monitor
   // ------------------------------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   initial begin
      link_clk_in = 1'b0;
      #13;
      forever #40 link_clk_in = ~link_clk_in;
   end
   always @(negedge line_oe_n_out) begin
      if (phase == 1) early = 1'b1;
      if (phase == 2 && first_low == 0) first_low = $realtime;
   end
   always @(posedge active_pullup_out) apu_seen = 1'b1;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         $display("BAD %0t %s", $time, msg);
         err_total++;
      end
   endtask

   function automatic realtime slot8_ns(input logic od);
      return 8.0 * (od ? SLOT_OD_NS : SLOT_STD_NS);
   endfunction

   task automatic do_cmd(input logic wr, input logic od, input logic strong_pullup_enable,
                         input logic active_pullup_enable, input logic [7:0] val);
      int n, s0;
      realtime t0;
      tx_byte = wr ? 8'hff : val;
      s0 = slots;
      @(posedge mclk_in);
      line_speed_select_in <= od;
      strong_pullup_enable_in <= strong_pullup_enable;
      active_pullup_enable_in <= active_pullup_enable;
      cmd_strobe_in <= 1'b1;
      cmd_code_in <= wr ? CMD_WRITE_BYTE : CMD_READ_BYTE;
      #1 chk(code_ack_out === 1'b1, "code not acked");
      phase = 1;
      early = 1'b0;
      apu_seen = 1'b0;
      first_low = 0;
      @(posedge mclk_in);
      cmd_strobe_in <= 1'b0;
      #1 chk(ptr_to_status_out === 1'b1, "no pointer pulse");
      chk(line_busy_flag_out === 1'b1, "busy not set");
      // a second command while busy must be refused
      @(posedge mclk_in);
      cmd_strobe_in <= 1'b1;
      cmd_code_in <= ($random(seed) & 1) ? CMD_WRITE_BYTE : CMD_READ_BYTE;
      #1 chk(code_ack_out === 1'b0, "busy command acked");
      @(posedge mclk_in);
      cmd_strobe_in <= 1'b0;
      #1 chk(ptr_to_status_out === 1'b0, "refused command moved ptr");
      repeat (3) @(posedge mclk_in);
      if (wr) begin
         data_strobe_in <= 1'b1;
         data_byte_in <= val;
         #1 chk(data_ack_out === 1'b1, "data byte not acked");
      end else begin
         code_ack_edge_in <= 1'b1;
         data_strobe_in <= 1'b1;
         data_byte_in <= ~val;
         #1 chk(data_ack_out === 1'b0, "stray data acked");
      end
      t0 = $realtime;
      phase = 2;
      @(posedge mclk_in);
      data_strobe_in <= 1'b0;
      code_ack_edge_in <= 1'b0;
      n = 0;
      while (line_busy_flag_out === 1'b1 && n < WAIT_LIMIT) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      if (n >= WAIT_LIMIT) begin
         $display("BAD %0t busy flag never cleared", $time);
         err_total++;
         finish_test();
      end
      phase = 0;
      chk(!early, "line active before byte complete");
      chk(first_low > t0 && first_low - t0 <= START_SLACK_NS,
          "late line start");
      chk($realtime - t0 >= slot8_ns(od), "busy too short");
      chk($realtime - t0 <= slot8_ns(od) + END_SLACK_NS,
          "command too long");
      chk(slots - s0 == 8, "slot count");
      chk(apu_seen === active_pullup_enable, "active pullup setting");
      if (wr) begin
         chk(rx_byte === val, "line byte wrong");
         chk(strong_pullup_out === strong_pullup_enable, "strong pullup setting");
      end else begin
         chk(read_data_out === val, "read data wrong");
         chk(rx_byte === val, "read slot not write-one");
         chk(strong_pullup_out === 1'b0, "strong pullup on read");
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 46711;
      err_total = 0;
      total_checks = 0;
      phase = 0;
      tx_byte = 8'hff;
      reset_in = 1'b1;
      cmd_strobe_in = 1'b0;
      cmd_code_in = 8'h00;
      code_ack_edge_in = 1'b0;
      data_strobe_in = 1'b0;
      data_byte_in = 8'h00;
      line_speed_select_in = 1'b0;
      strong_pullup_enable_in = 1'b0;
      active_pullup_enable_in = 1'b0;
      repeat (2) @(posedge mclk_in);
      reset_in <= 1'b0;
      #1 chk(line_busy_flag_out === 1'b0 && read_data_out === 8'h00 &&
          line_oe_n_out === 1'b1, "reset values");
      // data byte with no write pending, then an unknown code
      @(posedge mclk_in);
      data_strobe_in <= 1'b1;
      data_byte_in <= 8'h5a;
      #1 chk(data_ack_out === 1'b0, "orphan data acked");
      @(posedge mclk_in);
      data_strobe_in <= 1'b0;
      cmd_strobe_in <= 1'b1;
      cmd_code_in <= 8'h3c;
      @(posedge mclk_in);
      cmd_strobe_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      #1 chk(line_busy_flag_out === 1'b0, "unknown code started");
      // corner bytes first, then random traffic all at overdrive
      do_cmd(1'b1, 1'b0, 1'b1, 1'b1, 8'h01);
      do_cmd(1'b0, 1'b0, 1'b0, 1'b1, 8'h80);
      do_cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'hfe);
      do_cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      for (int i = 0; i < 8; i++) begin
         do_cmd(i[0], 1'b1, 1'($random(seed)), 1'($random(seed)),
                8'($random(seed)));
      end
      finish_test();
   end

   initial begin
      #4500000;
      $display("BAD %0t run limit reached", $time);
      err_total++;
      finish_test();
   end
endmodule
